// File: hrap_dev.sv
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
module hrap_dev (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	hrap_if.dev             link,
	output logic [7:0]      reg_addr_out,
	output logic [7:0]      reg_wdata_out,
	output logic            reg_wr_out,
	output logic            reg_rd_out,
	output logic            fifo_sel_out,
	input  wire logic [7:0] reg_rdata_in
);
	import hrap_pkg::*;

	logic [22:0]     sy1;
	logic [22:0]     sy2;
	logic            sclk_q;
	logic [2:0]      bit_cnt;
	logic [6:0]      rx_sr;
	hrap_ser_st_t    st;
	hrap_ser_st_t    next_st;
	logic [7:0]      hdr;
	logic [7:0]      next_hdr;
	logic [7:0]      wadr;
	logic [7:0]      next_wadr;
	logic            rdm;
	logic            next_rdm;
	logic [5:0]      ptr;
	logic [5:0]      next_ptr;
	logic            s_req_rd;
	logic            s_req_wr;
	logic [7:0]      s_req_adr;
	logic [1:0]      s_rdp;
	logic [7:0]      tx_sr;
	logic [3:0]      tx_cnt;
	logic            ale_q;
	logic            ale_vld;
	logic            mux_mode;
	logic            addr_mode_bit;
	logic [7:0]      idx;
	logic [7:0]      mux_adr;
	logic [7:0]      pdat_hold;
	logic            pact_q;
	logic            prd_q;
	logic            idxsel_q;
	logic [7:0]      ptgt_q;
	logic [1:0]      p_rdp;

	wire       s_sclk   = sy2[22];
	wire       s_cs_n   = sy2[21];
	wire       s_sdi    = sy2[20];
	wire       s_pcs_n  = sy2[19];
	wire       s_prw    = sy2[18];
	wire       s_pds    = sy2[17];
	wire       s_ale    = sy2[16];
	wire [7:0] s_paddr  = sy2[15:8];
	wire [7:0] s_pdat   = sy2[7:0];
	wire       s_rise   = s_sclk & ~sclk_q;
	wire       s_fall   = ~s_sclk & sclk_q;
	wire [7:0] rx_byte  = {rx_sr, s_sdi};
	wire       byte_done = ~s_cs_n & s_rise & (bit_cnt == 3'd7);
	wire       is_ram   = (hdr == HDR_NI_RAM) || (hdr == HDR_IL_RAM) || (hdr == HDR_AI_RAM);
	wire       is_ai    = (hdr == HDR_AI_REG) || (hdr == HDR_AI_RAM);
	wire       is_il    = (hdr == HDR_IL_REG) || (hdr == HDR_IL_RAM) || (hdr == HDR_IL_RW);
	wire       is_rw    = (hdr == HDR_NI_RW) || (hdr == HDR_IL_RW);
	wire [7:0] badr_map = {is_ram, rx_byte[6:0]};
	wire [7:0] wadr_inc = {wadr[7], wadr[6:0] + 7'd1};
	wire [5:0] ptr_inc  = ptr + 6'd1;
	wire       dir_bus  = s_ale & ~mux_mode;
	wire       pact     = s_cs_n & ~s_pcs_n & (dir_bus ? ~s_pds : (~s_prw | ~s_pds));
	wire       prd      = dir_bus ? s_prw : ~s_pds;
	wire [7:0] badr     = mux_mode ? mux_adr : s_paddr;
	wire       idxsel   = ~addr_mode_bit & ~badr[0];
	wire [7:0] ptgt     = addr_mode_bit ? badr : idx;
	wire       pstart   = pact & ~pact_q;
	wire       pstop    = ~pact & pact_q;
	wire       p_req_rd = pstart & prd & ~idxsel;
	wire       p_req_wr = pstop & ~prd_q & ~idxsel_q;

	function automatic logic hdr_known(input logic [7:0] h);
		hdr_known = (h == HDR_NI_REG) || (h == HDR_NI_RAM) || (h == HDR_IL_REG) ||
			(h == HDR_IL_RAM) || (h == HDR_AI_REG) || (h == HDR_AI_RAM) ||
			(h == HDR_FIFO) || (h == HDR_NI_RW) || (h == HDR_IL_RW);
	endfunction

	// Every pin passes two flops before use
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sy1    <= SYNC_RST;
			sy2    <= SYNC_RST;
			sclk_q <= 1'b1;
		end else begin
			sy1    <= {link.sclk, link.ser_cs_n, link.serial_in_line, link.par_cs_n,
				link.par_rw_wr_n, link.par_strobe_rd_n, link.par_ale, link.par_addr,
				link.par_data_bus};
			sy2    <= sy1;
			sclk_q <= sy2[22];
		end
	end

	// Byte assembly, MSB first on rising edges
	always_ff @(posedge clk_in) begin
		if (rst_in || s_cs_n) begin
			bit_cnt <= 3'd0;
			rx_sr   <= 7'h00;
		end else if (s_rise) begin
			bit_cnt <= bit_cnt + 3'd1;
			rx_sr   <= rx_byte[6:0];
		end
	end

	always_comb begin
		next_st   = st;
		next_hdr  = hdr;
		next_wadr = wadr;
		next_rdm  = rdm;
		next_ptr  = ptr;
		s_req_rd  = 1'b0;
		s_req_wr  = 1'b0;
		s_req_adr = wadr;
		if (byte_done) begin
			unique case (st)
				S_HDR: begin
					next_hdr = rx_byte;
					next_st  = hdr_known(rx_byte) ? S_ADR : S_IGN;
				end
				S_ADR: begin
					next_wadr = badr_map;
					next_rdm  = rx_byte[7];
					s_req_rd  = rx_byte[7];
					s_req_adr = (hdr == HDR_FIFO) ? {2'b00, ptr} : badr_map;
					if (is_ai || hdr == HDR_FIFO)
						next_st = S_BURST;
					else if (!rx_byte[7])
						next_st = is_rw ? S_BURST : S_DAT;
					else if (is_il)
						next_st = S_ADR;
					else
						next_st = S_DAT;
				end
				S_DAT: begin
					s_req_wr = ~rdm;
					next_st  = S_ADR;
				end
				S_BURST: begin
					s_req_rd = rdm;
					s_req_wr = ~rdm;
					if (hdr == HDR_FIFO) begin
						next_ptr  = ptr_inc;
						s_req_adr = rdm ? {2'b00, ptr_inc} : {2'b00, ptr};
					end else if (is_ai) begin
						next_wadr = wadr_inc;
						s_req_adr = rdm ? wadr_inc : wadr;
					end
				end
				S_IGN: begin
					next_st = S_IGN;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st   <= S_HDR;
			hdr  <= 8'h00;
			wadr <= 8'h00;
			rdm  <= 1'b0;
		end else if (s_cs_n) begin
			st   <= S_HDR;
		end else begin
			st   <= next_st;
			hdr  <= next_hdr;
			wadr <= next_wadr;
			rdm  <= next_rdm;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			ptr <= FIFO_PTR_RST;
		else
			ptr <= next_ptr;
	end

	// Read data goes out on falling edges in the following slot
	always_ff @(posedge clk_in) begin
		if (rst_in || s_cs_n) begin
			tx_sr                <= 8'h00;
			tx_cnt               <= 4'h0;
			link.serial_out_line <= 1'b1;
			link.serial_out_oe_n <= 1'b1;
		end else if (s_rdp[1]) begin
			tx_sr  <= reg_rdata_in;
			tx_cnt <= TX_BITS;
		end else if (s_fall) begin
			if (tx_cnt != 4'h0) begin
				link.serial_out_line <= tx_sr[7];
				link.serial_out_oe_n <= 1'b0;
				tx_sr                <= {tx_sr[6:0], 1'b0};
				tx_cnt               <= tx_cnt - 4'h1;
			end else begin
				link.serial_out_oe_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ale_q    <= 1'b0;
			ale_vld  <= 1'b0;
			mux_mode <= 1'b0;
			mux_adr  <= 8'h00;
		end else begin
			ale_q   <= s_ale;
			ale_vld <= 1'b1;
			if (ale_vld && (s_ale != ale_q))
				mux_mode <= 1'b1;
			if (ale_vld && ale_q && !s_ale)
				mux_adr <= s_pdat;
		end
	end

	// Parallel strobe tracking
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pact_q    <= 1'b0;
			prd_q     <= 1'b0;
			idxsel_q  <= 1'b0;
			ptgt_q    <= 8'h00;
			pdat_hold <= 8'h00;
		end else begin
			pact_q <= pact;
			if (pact)
				pdat_hold <= s_pdat;
			if (pstart) begin
				prd_q    <= prd;
				idxsel_q <= idxsel;
				ptgt_q   <= ptgt;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			idx <= 8'h00;
		else if (pstop && !prd_q && idxsel_q)
			idx <= pdat_hold;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			addr_mode_bit <= 1'b0;
		else if (reg_wr_out && !fifo_sel_out && reg_addr_out == MODE_CONFIG_REG_TWO_ADR)
			addr_mode_bit <= reg_wdata_out[ADDR_MODE_BIT_POS];
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_rdp              <= 2'b00;
			p_rdp              <= 2'b00;
			link.dev_data      <= 8'hFF;
			link.dev_data_oe_n <= 1'b1;
		end else begin
			s_rdp              <= {s_rdp[0], s_req_rd};
			p_rdp              <= {p_rdp[0], p_req_rd};
			link.dev_data_oe_n <= ~(pact & prd);
			if (pstart && prd && idxsel)
				link.dev_data <= idx;
			else if (p_rdp[1])
				link.dev_data <= reg_rdata_in;
		end
	end

	// Internal access port; serial and parallel never overlap
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reg_rd_out    <= 1'b0;
			reg_wr_out    <= 1'b0;
			reg_addr_out  <= 8'h00;
			reg_wdata_out <= 8'h00;
			fifo_sel_out  <= 1'b0;
		end else begin
			reg_rd_out <= s_req_rd | p_req_rd;
			reg_wr_out <= s_req_wr | p_req_wr;
			if (s_req_rd || s_req_wr) begin
				reg_addr_out  <= s_req_adr;
				reg_wdata_out <= rx_byte;
				fifo_sel_out  <= (hdr == HDR_FIFO);
			end else if (p_req_rd || p_req_wr) begin
				reg_addr_out  <= pstart ? ptgt : ptgt_q;
				reg_wdata_out <= pdat_hold;
				fifo_sel_out  <= 1'b0;
			end
		end
	end
endmodule // hrap_dev

// File: hrap_pkg.sv
// Summary of operation
// - Select falls to start; rising samples, falling shifts
// - Host sends a header byte first
// - Headers 40/44: address/data pairs, registers or RAM
// - Non-interleaved read data follows its address slot
// - Headers 48/4C: read data overlaps next address
// - Headers 4A/4E: one start address, then burst
// - Headers 4A/4E: burst address increments after every data byte
// - Sequences unlimited; select rising ends each one
// - Header 43: FIFO access, pointer advances per byte
// - Header 41: pair reads, write address starts burst
// - Header 49: interleaved reads, then fixed-address writes
// - Address-latch level picks one of the two unmultiplexed buses
// - Any latch edge forces multiplexed mode until reset
// - Host puts address on separate lines when unmultiplexed
// - Multiplexed address captured by latch strobe first
// - Indirect addressing after reset; bit set gives direct
// - Host sets direct mode while still indirect
// - Indirect: lowest line picks address or data register
// - Host writes address register, then accesses data
package hrap_pkg;
	localparam logic [7:0]  HDR_NI_REG     = 8'h40;
	localparam logic [7:0]  HDR_NI_RAM     = 8'h44;
	localparam logic [7:0]  HDR_IL_REG     = 8'h48;
	localparam logic [7:0]  HDR_IL_RAM     = 8'h4C;
	localparam logic [7:0]  HDR_AI_REG     = 8'h4A;
	localparam logic [7:0]  HDR_AI_RAM     = 8'h4E;
	localparam logic [7:0]  HDR_FIFO       = 8'h43;
	localparam logic [7:0]  HDR_NI_RW      = 8'h41;
	localparam logic [7:0]  HDR_IL_RW      = 8'h49;
	localparam int          FIFO_PTR_W     = 6;
	localparam logic [5:0]  FIFO_PTR_RST   = 6'h00;
	localparam logic [7:0]  MODE_CONFIG_REG_TWO_ADR = 8'h3A;
	localparam int          ADDR_MODE_BIT_POS       = 0;
	localparam logic [22:0] SYNC_RST       = 23'h7FFFFF;
	localparam logic [3:0]  TX_BITS        = 4'h8;
	localparam int          CLK_PERIOD_NS  = 50;
	localparam int          SCLK_HALF_NS   = 400;
	localparam logic [3:0]  SCLK_HALF_CYC  = 4'(SCLK_HALF_NS / CLK_PERIOD_NS);
	localparam int          PAR_STB_NS     = 500;
	localparam logic [3:0]  PAR_STB_CYC    = 4'(PAR_STB_NS / CLK_PERIOD_NS);
	localparam int          PAR_SETUP_NS   = 100;
	localparam logic [3:0]  PAR_SETUP_CYC  = 4'(PAR_SETUP_NS / CLK_PERIOD_NS);
	localparam logic [7:0]  WB_SCTL        = 8'h00;
	localparam logic [7:0]  WB_SDATA       = 8'h04;
	localparam logic [7:0]  WB_STAT        = 8'h08;
	localparam logic [7:0]  WB_PCMD        = 8'h0C;
	localparam logic [1:0]  BUS_STROBE_DIR = 2'h0;
	localparam logic [1:0]  BUS_SEP_STROBE = 2'h1;
	localparam logic [1:0]  BUS_MUX        = 2'h2;

	typedef enum logic [4:0] {
		S_HDR   = 5'b00001,
		S_ADR   = 5'b00010,
		S_DAT   = 5'b00100,
		S_BURST = 5'b01000,
		S_IGN   = 5'b10000
	} hrap_ser_st_t;

	typedef enum logic [2:0] {
		SS_IDLE = 3'b001,
		SS_LOW  = 3'b010,
		SS_HIGH = 3'b100
	} hrap_shift_st_t;

	typedef enum logic [4:0] {
		P_IDLE  = 5'b00001,
		P_ALE   = 5'b00010,
		P_SETUP = 5'b00100,
		P_STB   = 5'b01000,
		P_HOLD  = 5'b10000
	} hrap_par_st_t;
endpackage

// File: hrap_if.sv
`timescale 1ns/1ns
interface hrap_if;
	logic       sclk;
	logic       ser_cs_n;
	logic       serial_in_line;
	logic       serial_out_line;
	logic       serial_out_oe_n;
	logic       serial_out_wire;
	logic       par_cs_n;
	logic       par_rw_wr_n;
	logic       par_strobe_rd_n;
	logic       par_ale;
	logic [7:0] par_addr;
	logic [7:0] host_data;
	logic       host_data_oe_n;
	logic [7:0] dev_data;
	logic       dev_data_oe_n;
	logic [7:0] par_data_bus;

	// Pull-ups on the shared lines
	assign serial_out_wire = serial_out_oe_n ? 1'b1 : serial_out_line;
	assign par_data_bus    = !host_data_oe_n ? host_data :
		(!dev_data_oe_n ? dev_data : 8'hFF);

	modport dev (
		input  sclk, ser_cs_n, serial_in_line, par_cs_n, par_rw_wr_n,
		input  par_strobe_rd_n, par_ale, par_addr, par_data_bus,
		output serial_out_line, serial_out_oe_n, dev_data, dev_data_oe_n
	);
	modport host (
		output sclk, ser_cs_n, serial_in_line, par_cs_n, par_rw_wr_n,
		output par_strobe_rd_n, par_ale, par_addr, host_data, host_data_oe_n,
		input  serial_out_wire, par_data_bus
	);
endinterface

// File: hrap_host.sv
`timescale 1ns/1ns
module hrap_host (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	hrap_if.host             link,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic [31:0]      wb_dat_out,
	output logic             wb_ack_out
);
	import hrap_pkg::*;

	logic [8:0]     sy1;
	logic [8:0]     sy2;
	hrap_shift_st_t sst;
	hrap_par_st_t   pst;
	logic [7:0]     s_tx;
	logic [7:0]     s_rx;
	logic [3:0]     s_div;
	logic [2:0]     s_bits;
	logic           cs_on;
	logic [7:0]     p_wdat;
	logic           p_we;
	logic [1:0]     p_mode;
	logic [7:0]     p_rdat;
	logic [3:0]     p_cnt;

	wire wb_do    = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in;
	wire wr_sctl  = wb_do & (wb_adr_in == WB_SCTL) & wb_sel_in[0];
	wire wr_sdata = wb_do & (wb_adr_in == WB_SDATA) & wb_sel_in[0] & (sst == SS_IDLE);
	wire wr_pcmd  = wb_do & (wb_adr_in == WB_PCMD) & (&wb_sel_in[2:0]) & (pst == P_IDLE);
	wire dir_bus  = (p_mode == BUS_STROBE_DIR);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sy1 <= 9'h1FF;
			sy2 <= 9'h1FF;
		end else begin
			sy1 <= {link.serial_out_wire, link.par_data_bus};
			sy2 <= sy1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
			unique case (wb_adr_in)
				WB_SCTL:  wb_dat_out <= {31'h00000000, cs_on};
				WB_SDATA: wb_dat_out <= {24'h000000, s_rx};
				WB_STAT:  wb_dat_out <= {30'h00000000, pst != P_IDLE, sst != SS_IDLE};
				WB_PCMD:  wb_dat_out <= {24'h000000, p_rdat};
				default:  wb_dat_out <= 32'h00000000;
			endcase
		end
	end

	// Software frames each sequence; header is its first byte
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cs_on         <= 1'b0;
			link.ser_cs_n <= 1'b1;
		end else begin
			if (wr_sctl)
				cs_on <= wb_dat_in[0];
			link.ser_cs_n <= ~cs_on;
		end
	end

	// Byte shifter: clock idles high, host changes data on falling edges
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sst                 <= SS_IDLE;
			s_tx                <= 8'h00;
			s_rx                <= 8'h00;
			s_div               <= 4'h0;
			s_bits              <= 3'd0;
			link.sclk           <= 1'b1;
			link.serial_in_line <= 1'b1;
		end else begin
			unique case (sst)
				SS_IDLE: if (wr_sdata) begin
					s_tx                <= {wb_dat_in[6:0], 1'b0};
					link.serial_in_line <= wb_dat_in[7];
					link.sclk           <= 1'b0;
					s_div               <= 4'h0;
					s_bits              <= 3'd0;
					sst                 <= SS_LOW;
				end
				SS_LOW: if (s_div == SCLK_HALF_CYC - 4'h1) begin
					s_div     <= 4'h0;
					link.sclk <= 1'b1;
					s_rx      <= {s_rx[6:0], sy2[8]};
					sst       <= SS_HIGH;
				end else begin
					s_div <= s_div + 4'h1;
				end
				SS_HIGH: if (s_div == SCLK_HALF_CYC - 4'h1) begin
					s_div <= 4'h0;
					if (s_bits == 3'd7) begin
						sst <= SS_IDLE;
					end else begin
						s_bits              <= s_bits + 3'd1;
						link.sclk           <= 1'b0;
						link.serial_in_line <= s_tx[7];
						s_tx                <= {s_tx[6:0], 1'b0};
						sst                 <= SS_LOW;
					end
				end else begin
					s_div <= s_div + 4'h1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pst                 <= P_IDLE;
			p_cnt               <= 4'h0;
			p_wdat              <= 8'h00;
			p_we                <= 1'b0;
			p_mode              <= BUS_STROBE_DIR;
			p_rdat              <= 8'h00;
			link.par_cs_n       <= 1'b1;
			link.par_rw_wr_n    <= 1'b1;
			link.par_strobe_rd_n <= 1'b1;
			link.par_ale        <= 1'b1;
			link.par_addr       <= 8'hFF;
			link.host_data      <= 8'hFF;
			link.host_data_oe_n <= 1'b1;
		end else begin
			p_cnt <= p_cnt + 4'h1;
			unique case (pst)
				P_IDLE: begin
					p_cnt <= 4'h0;
					if (wr_pcmd) begin
						p_wdat <= wb_dat_in[15:8];
						p_we   <= wb_dat_in[16];
						p_mode <= wb_dat_in[18:17];
						if (wb_dat_in[18:17] == BUS_MUX) begin
							link.par_addr       <= 8'hFF;
							link.host_data      <= wb_dat_in[7:0];
							link.host_data_oe_n <= 1'b0;
							link.par_ale        <= 1'b1;
							pst                 <= P_ALE;
						end else begin
							link.par_addr    <= wb_dat_in[7:0];
							link.par_ale     <= (wb_dat_in[18:17] == BUS_STROBE_DIR);
							link.par_cs_n    <= 1'b0;
							link.par_rw_wr_n <= (wb_dat_in[18:17] == BUS_STROBE_DIR) ?
								~wb_dat_in[16] : 1'b1;
							pst              <= P_SETUP;
						end
					end
				end
				P_ALE: if (p_cnt == PAR_SETUP_CYC) begin
					p_cnt         <= 4'h0;
					link.par_ale  <= 1'b0;
					link.par_cs_n <= 1'b0;
					pst           <= P_SETUP;
				end
				P_SETUP: if (p_cnt == PAR_SETUP_CYC) begin
					p_cnt               <= 4'h0;
					link.host_data      <= p_wdat;
					link.host_data_oe_n <= ~p_we;
					if (dir_bus || !p_we)
						link.par_strobe_rd_n <= 1'b0;
					else
						link.par_rw_wr_n <= 1'b0;
					pst                 <= P_STB;
				end
				P_STB: if (p_cnt == PAR_STB_CYC) begin
					p_cnt            <= 4'h0;
					p_rdat           <= sy2[7:0];
					link.par_strobe_rd_n <= 1'b1;
					if (!dir_bus)
						link.par_rw_wr_n <= 1'b1;
					pst              <= P_HOLD;
				end
				P_HOLD: if (p_cnt == PAR_SETUP_CYC) begin
					link.par_cs_n       <= 1'b1;
					link.par_rw_wr_n    <= 1'b1;
					link.host_data_oe_n <= 1'b1;
					pst                 <= P_IDLE;
				end
			endcase
		end
	end
endmodule // hrap_host

// File: hrap_chk.sv
`timescale 1ns/1ns
module hrap_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sclk,
	input wire logic ser_cs_n,
	input wire logic serial_out_line,
	input wire logic serial_out_oe_n,
	input wire logic par_cs_n,
	input wire logic par_rw_wr_n,
	input wire logic par_strobe_rd_n,
	input wire logic host_data_oe_n,
	input wire logic dev_data_oe_n
);
	logic [7:0] rises;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Shift clock rises within the current frame
	always_ff @(posedge clk_in) begin
		if (rst_in || ser_cs_n)
			rises <= 8'h00;
		else if ($rose(sclk))
			rises <= rises + 8'h01;
	end
	a_whole_bytes: assert property ($rose(ser_cs_n) |-> rises[2:0] == 3'h0)
		else $error("select raised inside a byte");
	a_sclk_idle_high: assert property (ser_cs_n |-> sclk)
		else $error("shift clock not idle high");
	a_sclk_low_half: assert property ($fell(sclk) |-> (!sclk) [*7])
		else $error("shift clock low phase too short");
	a_out_on_fall: assert property (!serial_out_oe_n && $changed(serial_out_line) |-> !sclk)
		else $error("serial output moved while clock high");
	a_drive_in_frame: assert property ($fell(serial_out_oe_n) |-> !sclk && !ser_cs_n)
		else $error("serial output enabled outside a frame");
	a_release_desel: assert property (ser_cs_n [*6] |-> serial_out_oe_n)
		else $error("serial output driven after deselect");
	a_no_contention: assert property (!dev_data_oe_n |-> host_data_oe_n && par_rw_wr_n)
		else $error("device drives bus outside a read");
	a_rd_release: assert property ($rose(par_strobe_rd_n) |-> ##[0:6] dev_data_oe_n)
		else $error("device holds bus after strobe");
	a_strobe_in_cs: assert property ($fell(par_strobe_rd_n) |-> !par_cs_n && (!par_strobe_rd_n) [*8])
		else $error("parallel strobe short or unselected");
endmodule // hrap_chk

// File: host_register_access_port_tb.sv
`timescale 1ns/1ns
module host_register_access_port_tb;
	import hrap_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        cyc    = 1'b0;
	logic        stb    = 1'b0;
	logic        we     = 1'b0;
	logic [7:0]  adr    = 8'h00;
	logic [31:0] wdat   = 32'h0;
	logic [7:0]  rdv    = 8'h00;
	logic [31:0] seed   = 32'h0000EBCB;
	logic [31:0] rdat, rq;
	logic        ack, r_wr, r_rd, r_fifo;
	logic [7:0]  r_addr, r_wdata;
	logic [18:0] notes[$];
	logic [7:0]  hl[4] = '{HDR_NI_REG, HDR_NI_RAM, HDR_IL_REG, HDR_IL_RAM};
	int          fails = 0;
	int          compares = 0;

	always #25 clk_in = ~clk_in;
	hrap_if link ();
	hrap_host hrap_host_inst (.clk_in(clk_in), .rst_in(rst_in), .link(link), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack));
	hrap_dev hrap_dev_inst (.clk_in(clk_in), .rst_in(rst_in), .link(link), .reg_addr_out(r_addr),
		.reg_wdata_out(r_wdata), .reg_wr_out(r_wr), .reg_rd_out(r_rd), .fifo_sel_out(r_fifo),
		.reg_rdata_in(rdv));
	hrap_chk hrap_chk_inst (.clk_in(clk_in), .rst_in(rst_in), .sclk(link.sclk),
		.ser_cs_n(link.ser_cs_n), .serial_out_line(link.serial_out_line),
		.serial_out_oe_n(link.serial_out_oe_n), .par_cs_n(link.par_cs_n),
		.par_rw_wr_n(link.par_rw_wr_n), .par_strobe_rd_n(link.par_strobe_rd_n),
		.host_data_oe_n(link.host_data_oe_n), .dev_data_oe_n(link.dev_data_oe_n));

	function automatic logic [7:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic chk(input logic [18:0] got, input logic [18:0] want);
		compares++;
		if (got !== want) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask

	task note(input logic rd, input logic f, input logic [7:0] a, input logic [7:0] d);
		notes.push_back({rd, f, a, d});
	endtask

	// Every register strobe of the device is matched against the oldest note
	always @(posedge clk_in) begin
		if (r_wr === 1'b1 || r_rd === 1'b1)
			chk({r_rd, r_fifo, r_addr, r_rd ? 8'h00 : r_wdata},
				notes.size() ? notes.pop_front() : 19'h7FFFF);
	end

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			fails++;
			end_of_test();
		end
		rq = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task idle();
		int n;
		n = 0;
		do begin
			wb(1'b0, WB_STAT, 32'h0);
			n++;
		end while (rq[1:0] !== 2'h0 && n < 400);
		if (rq[1:0] !== 2'h0) begin
			fails++;
			end_of_test();
		end
	endtask

	task sb(input logic [7:0] b);
		wb(1'b1, WB_SDATA, {24'h0, b});
		idle();
	endtask

	task cs(input logic s);
		wb(1'b1, WB_SCTL, {31'h0, s});
	endtask

	task rx(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 32'h0);
		chk({11'h0, rq[7:0]}, {11'h0, e});
	endtask

	task par(input logic w, input logic [1:0] bus, input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, WB_PCMD, {13'h0, bus, w, d, a});
		idle();
	endtask

	task end_of_test();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clk_in);
		fails++;
		end_of_test();
	end

	initial begin
		logic [7:0] h, off, d, st;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			h = hl[i];
			off = {h[2], 7'h0};
			cs(1'b1);
			sb(h);
			d = xs();
			note(1'b0, 1'b0, off | 8'h12, d);
			sb(8'h12);
			sb(d);
			rdv <= xs();
			note(1'b1, 1'b0, off | 8'h05, 8'h00);
			sb(8'h85);
			if (h[3]) begin
				note(1'b0, 1'b0, off | 8'h13, d);
				sb(8'h13);
				rx(WB_SDATA, rdv);
				sb(d);
			end else begin
				sb(8'hFF);
				rx(WB_SDATA, rdv);
			end
			cs(1'b0);
		end
		$display("pair sequences done");
		for (int i = 0; i < 2; i++) begin
			h = i ? HDR_AI_RAM : HDR_AI_REG;
			off = {h[2], 7'h0};
			st = i ? 8'h7E : 8'h20;
			cs(1'b1);
			sb(h);
			sb(st);
			for (int k = 0; k < 3; k++) begin
				d = xs();
				note(1'b0, 1'b0, off | ((st + 8'(k)) & 8'h7F), d);
				sb(d);
			end
			cs(1'b0);
		end
		$display("burst sequences done");
		cs(1'b1);
		sb(HDR_FIFO);
		sb(8'h1F);
		for (int k = 0; k < 3; k++) begin
			d = xs();
			note(1'b0, 1'b1, {2'h0, 6'(k)}, d);
			sb(d);
		end
		cs(1'b0);
		$display("queue sequence done");
		for (int i = 0; i < 2; i++) begin
			cs(1'b1);
			sb(i ? HDR_IL_RW : HDR_NI_RW);
			rdv <= xs();
			note(1'b1, 1'b0, 8'h07, 8'h00);
			sb(8'h87);
			if (i == 0) begin
				sb(8'hFF);
				rx(WB_SDATA, rdv);
			end
			sb(8'h30);
			if (i == 1)
				rx(WB_SDATA, rdv);
			for (int k = 0; k < 2; k++) begin
				d = xs();
				note(1'b0, 1'b0, 8'h30, d);
				sb(d);
			end
			cs(1'b0);
		end
		$display("read then write sequences done");
		cs(1'b1);
		sb(8'h55);
		sb(8'h12);
		sb(8'h34);
		rx(WB_SDATA, 8'hFF);
		cs(1'b0);
		$display("unknown header done");
		par(1'b1, BUS_STROBE_DIR, 8'hFE, MODE_CONFIG_REG_TWO_ADR);
		note(1'b0, 1'b0, MODE_CONFIG_REG_TWO_ADR, 8'h01);
		par(1'b1, BUS_STROBE_DIR, 8'hFF, 8'h01);
		d = xs();
		note(1'b0, 1'b0, 8'h15, d);
		par(1'b1, BUS_STROBE_DIR, 8'h15, d);
		rdv <= xs();
		note(1'b1, 1'b0, 8'h16, 8'h00);
		par(1'b0, BUS_STROBE_DIR, 8'h16, 8'h00);
		rx(WB_PCMD, rdv);
		d = xs();
		note(1'b0, 1'b0, 8'h18, d);
		par(1'b1, BUS_MUX, 8'h18, d);
		rst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		par(1'b1, BUS_STROBE_DIR, 8'hFE, 8'h21);
		d = xs();
		note(1'b0, 1'b0, 8'h21, d);
		par(1'b1, BUS_STROBE_DIR, 8'hFF, d);
		// Separate strobes drop the latch line: the port turns multiplexed
		rdv <= xs();
		note(1'b1, 1'b0, 8'h21, 8'h00);
		par(1'b0, BUS_SEP_STROBE, 8'hFF, 8'h00);
		rx(WB_PCMD, rdv);
		$display("parallel accesses done");
		repeat (10) @(posedge clk_in);
		chk(19'(notes.size()), 19'h0);
		end_of_test();
	end
endmodule // host_register_access_port_tb
